// ===== hw/dac_ref_pkg.sv
// shared constants and types for the converter reference and command logic
// assumes one system clock; serial bus pins arrive asynchronously
`default_nettype none
package dac_ref_pkg;
	localparam int CHANNELS = 8;
	localparam int CODE_W = 12;
	localparam int CMD_W = 24;
	localparam int BYTE_W = 8;
	localparam int CMD_BYTES = 3;
	// command word fields, bit positions inside the 24-bit word
	localparam int NIB_HI = 23;
	localparam int NIB_LO = 20;
	localparam int ACC_HI = 19;
	localparam int ACC_LO = 16;
	localparam int STATIC_ON_POS = 4;
	localparam int FLEX_SEL_POS = 14;
	localparam int FLEX_SUB_HI = 13;
	localparam int FLEX_SUB_LO = 12;
	localparam int PD_MODE_HI = 14;
	localparam int PD_MODE_LO = 13;
	localparam int PD_MASK_LO = 5;
	localparam int CODE_LO = 4;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_CHAN_POWER = 4'h4;
	localparam logic [3:0] CMD_REF_STATIC = 4'h8;
	localparam logic [3:0] CMD_REF_FLEX = 4'h9;
	localparam logic [3:0] ACCESS_ALL = 4'hF;
	localparam logic [1:0] FLEX_SUB_AUTO = 2'h0;
	localparam logic [1:0] FLEX_SUB_ON = 2'h1;
	localparam logic [1:0] FLEX_SUB_OFF = 2'h2;
	localparam logic [1:0] PD_MODE_UP = 2'h0;
	localparam logic [CODE_W-1:0] TWOS_FLIP = 12'h800;
	// register port
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 32;
	localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [6:0] SLAVE_ADDR_RESET = 7'h48;
	typedef enum logic [1:0] {FLEX_AUTO, FLEX_ON, FLEX_OFF} flex_sel_t;
	typedef struct packed {
		logic      flex_mode;
		flex_sel_t flex_sel;
		logic      static_on;
	} ref_ctrl_t;
	typedef logic [CHANNELS-1:0][CODE_W-1:0] code_bank_t;
endpackage : dac_ref_pkg
`default_nettype wire

// ===== hw/pin_sync.sv
// two-stage synchroniser with edge detection for asynchronous pins
// assumes pins are slow against sys_clk (at least a few samples per level)
`default_nettype none
module pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] last_reg;

	// idle bus lines are high, so reset to high avoids a false edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '1;
			sync_reg <= '1;
			last_reg <= '1;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;
endmodule : pin_sync
`default_nettype wire

// ===== hw/code_formatter.sv
// registered per-channel code format conversion to straight binary
// assumes format select is already synchronised
`default_nettype none
module code_formatter (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    twos_format,
	input  wire dac_ref_pkg::code_bank_t codes_in,
	output dac_ref_pkg::code_bank_t      codes_out
);
	function automatic logic [dac_ref_pkg::CODE_W-1:0] to_binary(
		input logic [dac_ref_pkg::CODE_W-1:0] c,
		input logic twos
	);
		to_binary = twos ? (c ^ dac_ref_pkg::TWOS_FLIP) : c;
	endfunction : to_binary

	for (genvar i = 0; i < dac_ref_pkg::CHANNELS; i++) begin : g_chan
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				codes_out[i] <= '0;
			end else begin
				codes_out[i] <= to_binary(codes_in[i], twos_format);
			end
		end
	end

	twos_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
		twos_format |=> codes_out[0] == ($past(codes_in[0]) ^ dac_ref_pkg::TWOS_FLIP))
		else $error("twos complement code not converted");
endmodule : code_formatter
`default_nettype wire

// ===== hw/dac_reference_control.sv
// octal converter command interpreter: serial slave, reference and code control
// assumes a write-only two-wire master; pins are asynchronous to sys_clk
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`default_nettype none
module dac_reference_control #(
	parameter int         CHANNELS   = dac_ref_pkg::CHANNELS,
	parameter bit         LEADLESS   = 1'b1,
	parameter logic [6:0] ADDR_RESET = dac_ref_pkg::SLAVE_ADDR_RESET
) (
	input  wire logic                               sys_clk,
	input  wire logic                               resetn,
	input  wire logic                               scl_in,
	input  wire logic                               sda_in,
	output logic                                    sda_out,
	output logic                                    sda_oe,
	input  wire logic                               code_format_select,
	input  wire logic [dac_ref_pkg::REG_ADDR_W-1:0] reg_addr,
	input  wire logic [dac_ref_pkg::REG_DATA_W-1:0] reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [dac_ref_pkg::REG_DATA_W-1:0] reg_rdata,
	output logic                                    ref_enable,
	output logic                                    shared_reference_pin_oe,
	output logic                                    gain_divider_path_short,
	output logic      [CHANNELS-1:0]                chan_powered,
	output dac_ref_pkg::code_bank_t                 chan_code
);
	if (CHANNELS != dac_ref_pkg::CHANNELS) begin : g_check
		$error("channel count must match the code bank");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK, ST_IGNORE} bus_state_t;

	logic                           rst_meta_reg;
	logic                           rst_n;
	logic [1:0]                     pin_lvl;
	logic [1:0]                     pin_rise;
	logic [1:0]                     pin_fall;
	logic                           fmt_lvl;
	logic                           scl_rise;
	logic                           scl_fall;
	logic                           bus_start;
	logic                           bus_stop;
	bus_state_t                     state_reg;
	logic [3:0]                     bit_cnt_reg;
	logic [1:0]                     byte_cnt_reg;
	logic [7:0]                     shift_reg;
	logic [dac_ref_pkg::CMD_W-1:0]  cmd_word_reg;
	logic                           cmd_valid_reg;
	logic [6:0]                     slave_addr_reg;
	dac_ref_pkg::ref_ctrl_t         ref_ctrl_reg;
	logic                           ref_on_reg;
	logic                           ref_on_next;
	logic [CHANNELS-1:0]            power_reg;
	dac_ref_pkg::code_bank_t        code_reg;
	logic                           twos_sel;
	logic [3:0]                     cmd_nibble;
	logic [3:0]                     channel_access_nibble;
	logic                           any_up;

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	pin_sync #(.W(2)) u_bus_sync (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.pin   ({scl_in, sda_in}),
		.level (pin_lvl),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	pin_sync #(.W(1)) u_fmt_sync (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.pin   (code_format_select),
		.level (fmt_lvl),
		.rise  (),
		.fall  ()
	);

	assign scl_rise  = pin_rise[1];
	assign scl_fall  = pin_fall[1];
	assign bus_start = pin_lvl[1] & pin_fall[0];
	assign bus_stop  = pin_lvl[1] & pin_rise[0];

	function automatic logic addr_ok(input logic [7:0] b, input logic [6:0] a);
		// reads are not served: a read address is left unacknowledged
		addr_ok = (b[7:1] == a) && !b[0];
	endfunction : addr_ok

	// serial slave receiver
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			byte_cnt_reg <= 2'h0;
			shift_reg    <= 8'h00;
			cmd_word_reg <= 24'h000000;
			sda_oe       <= 1'b0;
		end else if (bus_start) begin
			state_reg    <= ST_RECV;
			bit_cnt_reg  <= 4'h0;
			byte_cnt_reg <= 2'h0;
			sda_oe       <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= ST_IDLE;
			sda_oe    <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE, ST_IGNORE: begin
				end
				ST_RECV: begin
					if (scl_rise && bit_cnt_reg < 4'h8) begin
						shift_reg   <= {shift_reg[6:0], pin_lvl[0]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						if (byte_cnt_reg == 2'h0 && !addr_ok(shift_reg, slave_addr_reg)) begin
							state_reg <= ST_IGNORE;
						end else begin
							state_reg <= ST_ACK;
							sda_oe    <= 1'b1;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe      <= 1'b0;
						bit_cnt_reg <= 4'h0;
						state_reg   <= ST_RECV;
						if (byte_cnt_reg != 2'h0) begin
							cmd_word_reg <= {cmd_word_reg[15:0], shift_reg};
						end
						// further words in the same frame start again at byte one
						byte_cnt_reg <= (byte_cnt_reg == 2'h3) ? 2'h1 : byte_cnt_reg + 2'h1;
					end
				end
			endcase
		end
	end

	// a command is released only at the end of its third acknowledged byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= (state_reg == ST_ACK) && scl_fall && (byte_cnt_reg == 2'h3)
				&& !bus_start && !bus_stop;
		end
	end

	// acknowledge drives low; the line is open drain
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	assign cmd_nibble            = cmd_word_reg[dac_ref_pkg::NIB_HI:dac_ref_pkg::NIB_LO];
	assign channel_access_nibble = cmd_word_reg[dac_ref_pkg::ACC_HI:dac_ref_pkg::ACC_LO];
	assign any_up                = |power_reg;

	// reference control state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_ctrl_reg <= '{flex_mode: 1'b0, flex_sel: dac_ref_pkg::FLEX_OFF, static_on: 1'b0};
		end else if (cmd_valid_reg) begin
			if (cmd_nibble == dac_ref_pkg::CMD_REF_STATIC && !ref_ctrl_reg.flex_mode) begin
				ref_ctrl_reg.static_on <= cmd_word_reg[dac_ref_pkg::STATIC_ON_POS];
			end
			if (cmd_nibble == dac_ref_pkg::CMD_REF_FLEX) begin
				if (!cmd_word_reg[dac_ref_pkg::FLEX_SEL_POS]) begin
					ref_ctrl_reg.flex_mode <= 1'b0;
				end else begin
					unique case (cmd_word_reg[dac_ref_pkg::FLEX_SUB_HI:dac_ref_pkg::FLEX_SUB_LO])
						dac_ref_pkg::FLEX_SUB_AUTO: begin
							ref_ctrl_reg.flex_mode <= 1'b1;
							ref_ctrl_reg.flex_sel  <= dac_ref_pkg::FLEX_AUTO;
						end
						dac_ref_pkg::FLEX_SUB_ON: begin
							ref_ctrl_reg.flex_mode <= 1'b1;
							ref_ctrl_reg.flex_sel  <= dac_ref_pkg::FLEX_ON;
						end
						dac_ref_pkg::FLEX_SUB_OFF: begin
							ref_ctrl_reg.flex_mode <= 1'b1;
							ref_ctrl_reg.flex_sel  <= dac_ref_pkg::FLEX_OFF;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// channel power state, broadcast over a mask
	for (genvar i = 0; i < CHANNELS; i++) begin : g_power
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				power_reg[i] <= 1'b1;
			end else if (cmd_valid_reg && cmd_nibble == dac_ref_pkg::CMD_CHAN_POWER
				&& cmd_word_reg[dac_ref_pkg::PD_MASK_LO + i]) begin
				power_reg[i] <= cmd_word_reg[dac_ref_pkg::PD_MODE_HI:dac_ref_pkg::PD_MODE_LO]
					== dac_ref_pkg::PD_MODE_UP;
			end
		end
	end

	// channel code registers; codes are plain 12-bit values
	for (genvar i = 0; i < CHANNELS; i++) begin : g_code
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				code_reg[i] <= '0;
			end else if (cmd_valid_reg && cmd_nibble == dac_ref_pkg::CMD_WRITE_UPDATE
				&& (channel_access_nibble == 4'(i)
				|| channel_access_nibble == dac_ref_pkg::ACCESS_ALL)) begin
				code_reg[i] <= cmd_word_reg[dac_ref_pkg::CODE_LO + dac_ref_pkg::CODE_W - 1
					:dac_ref_pkg::CODE_LO];
			end
		end
	end

	always_comb begin
		if (ref_ctrl_reg.flex_mode) begin
			unique case (ref_ctrl_reg.flex_sel)
				dac_ref_pkg::FLEX_ON:   ref_on_next = 1'b1;
				dac_ref_pkg::FLEX_AUTO: ref_on_next = any_up;
				default:                ref_on_next = 1'b0;
			endcase
		end else begin
			ref_on_next = ref_ctrl_reg.static_on & any_up;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_on_reg <= 1'b0;
		end else begin
			ref_on_reg <= ref_on_next;
		end
	end

	// pin drive and gain switch follow the reference one cycle later
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_enable              <= 1'b0;
			shared_reference_pin_oe <= 1'b0;
			gain_divider_path_short <= 1'b0;
			chan_powered            <= '1;
		end else begin
			ref_enable              <= ref_on_reg;
			shared_reference_pin_oe <= ref_on_reg;
			gain_divider_path_short <= ref_on_reg;
			chan_powered            <= power_reg;
		end
	end

	// the 16-lead build has no format pin and is fixed to straight binary
	assign twos_sel = LEADLESS ? fmt_lvl : 1'b0;

	code_formatter u_fmt (
		.clk         (sys_clk),
		.rst_n       (rst_n),
		.twos_format (twos_sel),
		.codes_in    (code_reg),
		.codes_out   (chan_code)
	);

	// register port
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slave_addr_reg <= ADDR_RESET;
		end else if (reg_wr && reg_addr == dac_ref_pkg::REG_CTRL) begin
			slave_addr_reg <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				dac_ref_pkg::REG_CTRL:   reg_rdata <= {25'h0, slave_addr_reg};
				dac_ref_pkg::REG_STATUS: reg_rdata <= {19'h0, ref_on_reg, ref_ctrl_reg,
					power_reg};
				default:                 reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	ref_rise_cause_a: assert property ($rose(ref_on_reg) |-> $past(cmd_valid_reg, 2))
		else $error("reference rose without a command");
	cmd_after_ack_a: assert property (cmd_valid_reg |->
		$past(state_reg == ST_ACK && byte_cnt_reg == 2'h3 && scl_fall))
		else $error("command released before the third acknowledge");
	static_on_a: assert property (cmd_valid_reg && !ref_ctrl_reg.flex_mode
		&& cmd_nibble == dac_ref_pkg::CMD_REF_STATIC
		&& cmd_word_reg[dac_ref_pkg::STATIC_ON_POS] && any_up
		|=> ##1 ref_on_reg)
		else $error("static on command ignored");
	static_off_a: assert property (cmd_valid_reg && !ref_ctrl_reg.flex_mode
		&& cmd_nibble == dac_ref_pkg::CMD_REF_STATIC
		&& !cmd_word_reg[dac_ref_pkg::STATIC_ON_POS] |=> ##1 !ref_on_reg)
		else $error("static off command ignored");
	auto_down_a: assert property (!ref_ctrl_reg.flex_mode && power_reg == '0
		|=> !ref_on_reg)
		else $error("reference kept on with all channels down");
	auto_up_a: assert property (!ref_ctrl_reg.flex_mode && ref_ctrl_reg.static_on
		&& $rose(any_up) |=> ref_on_reg)
		else $error("reference not restored by channel power up");
	flex_static_ign_a: assert property (ref_ctrl_reg.flex_mode && cmd_valid_reg
		&& cmd_nibble == dac_ref_pkg::CMD_REF_STATIC |=> $stable(ref_ctrl_reg))
		else $error("static command acted in flexible mode");
	flex_always_on_a: assert property (ref_ctrl_reg.flex_mode
		&& ref_ctrl_reg.flex_sel == dac_ref_pkg::FLEX_ON |=> ref_on_reg)
		else $error("always on reference dropped");
	flex_enter_a: assert property (cmd_valid_reg && cmd_nibble == dac_ref_pkg::CMD_REF_FLEX
		&& cmd_word_reg[14:12] == 3'h6 |=> ref_ctrl_reg.flex_mode ##1 !ref_on_reg)
		else $error("flexible off command not taken");
	pin_release_a: assert property (!ref_on_reg |=> !shared_reference_pin_oe
		&& !gain_divider_path_short)
		else $error("reference pin or divider driven while off");
	gain_two_a: assert property (ref_on_reg[*2] |-> gain_divider_path_short)
		else $error("gain two not selected with internal reference");
	ack_drive_a: assert property (sda_oe == (state_reg == ST_ACK))
		else $error("acknowledge drive out of step with the receiver");

	static_on_c: cover property (!ref_ctrl_reg.flex_mode && $rose(ref_on_reg));
	flex_on_c: cover property (ref_ctrl_reg.flex_sel == dac_ref_pkg::FLEX_ON
		&& ref_ctrl_reg.flex_mode && power_reg == '0);
	auto_down_c: cover property (ref_ctrl_reg.static_on && $fell(ref_on_reg));
	code_write_c: cover property (cmd_valid_reg && cmd_nibble == dac_ref_pkg::CMD_WRITE_UPDATE);
endmodule : dac_reference_control
`default_nettype wire

// ===== tb/serial_master_model.sv
// serial bus master model: clock and open-drain data toward the converter
// assumes a pull-up on the data wire; data_line is the resolved level
`default_nettype none
module serial_master_model (
	input  wire logic sys_clk,
	input  wire logic data_line,
	output var  logic scl_line,
	output var  logic data_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// clock rests high between frames, data released to the pull-up
	initial begin
		scl_line = 1'b1;
		data_low = 1'b0;
	end
	// a quarter of the 320 ns link period is two system clocks
	task automatic wait_q(input int n);
		repeat (2 * n) @(posedge sys_clk);
	endtask : wait_q
	// stretch lengthens the low phase to act as a slow master
	task automatic put_bit(input logic b, input int stretch, output logic seen);
		data_low <= ~b;
		wait_q(1 + stretch);
		scl_line <= 1'b1;
		wait_q(1);
		seen = data_line;
		wait_q(1);
		scl_line <= 1'b0;
		wait_q(1);
	endtask : put_bit
	// nbytes below 3 stops mid-word, which the device must discard
	task automatic xfer(input logic [7:0] adr, input logic [23:0] word, input int nbytes,
			input int stretch, output logic acked);
		logic [31:0] frame;
		logic        seen;
		frame = {adr, word};
		acked = 1'b1;
		data_low <= 1'b1;
		wait_q(2);
		scl_line <= 1'b0;
		wait_q(1);
		for (int i = 0; i < 8 * (nbytes + 1); i++) begin
			put_bit(frame[31-i], stretch, seen);
			if (i % 8 == 7) begin
				put_bit(1'b1, stretch, seen);
				acked = acked & ~seen;
			end
		end
		data_low <= 1'b1;
		wait_q(1);
		scl_line <= 1'b1;
		wait_q(2);
		data_low <= 1'b0;
		wait_q(2);
	endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// ===== tb/dac_reference_control_tb.sv
// self-checking bench: serial commands, reference state, codes and register port
// assumes the design package and the serial master model are compiled first
`default_nettype none
module dac_reference_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                               sys_clk, resetn, code_format_select;
	logic [dac_ref_pkg::REG_ADDR_W-1:0] reg_addr;
	logic [dac_ref_pkg::REG_DATA_W-1:0] reg_wdata, reg_rdata, rd;
	logic                               reg_wr, reg_rd, scl, m_low, sda_out, sda_oe, sda;
	logic                               ref_enable, pin_oe, gain_short, ack;
	logic [7:0]                         chan_powered, e_pw;
	dac_ref_pkg::code_bank_t            chan_code;
	dac_ref_pkg::code_bank_t            chan_code_binary;
	logic                               e_static, e_flex;
	logic [1:0]                         e_sel;
	logic [11:0]                        e_code [8];
	logic [6:0]                         slave_addr;
	int                                 seed = 32'hFA18;
	int                                 checked, miscompares;
	localparam logic [23:0] CORNER [16] = '{
		24'h800010, 24'h403FE0, 24'h400020, 24'h80FFEF, 24'h800010, 24'h904000,
		24'h800000, 24'h403FE0, 24'h905000, 24'h906000, 24'h907000, 24'h900000,
		24'h3FABC0, 24'h35FFF0, 24'h300000, 24'h401FE0};
	// open-drain data wire with its pull-up
	assign sda = ~(m_low | (sda_oe & ~sda_out));
	serial_master_model master (.sys_clk(sys_clk), .data_line(sda), .scl_line(scl),
		.data_low(m_low));
	dac_reference_control dut (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.code_format_select(code_format_select), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ref_enable(ref_enable), .shared_reference_pin_oe(pin_oe),
		.gain_divider_path_short(gain_short), .chan_powered(chan_powered),
		.chan_code(chan_code));
	// 16-lead build on the same bus: listens only, its acknowledge is left unconnected
	dac_reference_control #(.LEADLESS(1'b0)) dut_binary (.sys_clk(sys_clk), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(),
		.code_format_select(code_format_select), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
		.ref_enable(), .shared_reference_pin_oe(), .gain_divider_path_short(),
		.chan_powered(), .chan_code(chan_code_binary));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	task automatic do_reset();
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		// format synchroniser resets high, so codes settle only a few cycles after release
		repeat (8) @(posedge sys_clk);
		e_static = 1'b0;
		e_flex = 1'b0;
		e_sel = 2'h2;
		e_pw = 8'hFF;
		slave_addr = 7'h48;
		foreach (e_code[i]) e_code[i] = 12'h000;
	endtask : do_reset
	task automatic model_cmd(input logic [23:0] w);
		case (w[23:20])
			dac_ref_pkg::CMD_REF_STATIC: if (!e_flex) e_static = w[4];
			dac_ref_pkg::CMD_REF_FLEX: begin
				if (!w[14]) e_flex = 1'b0;
				else if (w[13:12] != 2'h3) begin
					e_flex = 1'b1;
					e_sel = w[13:12];
				end
			end
			dac_ref_pkg::CMD_WRITE_UPDATE: begin
				foreach (e_code[i]) begin
					if (w[19:16] == 4'(i) || w[19:16] == 4'hF) e_code[i] = w[15:4];
				end
			end
			dac_ref_pkg::CMD_CHAN_POWER: e_pw = (w[14:13] == 2'h0) ? e_pw | w[12:5] : e_pw & ~w[12:5];
			default: ;
		endcase
	endtask : model_cmd
	task automatic check_all();
		logic on;
		on = e_flex ? (e_sel == 2'h1 || (e_sel == 2'h0 && e_pw != 8'h00))
			: (e_static && e_pw != 8'h00);
		check(32'(ref_enable), 32'(on));
		check(32'(pin_oe), 32'(on));
		check(32'(gain_short), 32'(on));
		check(32'(chan_powered), 32'(e_pw));
		foreach (e_code[i]) begin
			check(32'(chan_code[i]), 32'(e_code[i] ^ {code_format_select, 11'h000}));
			check(32'(chan_code_binary[i]), 32'(e_code[i]));
		end
		reg_read(dac_ref_pkg::REG_STATUS, rd);
		check(rd, {19'h0, on, e_flex, e_sel, e_static, e_pw});
	endtask : check_all
	// the format pin changes at random before each frame
	task automatic send(input logic [23:0] w, input int nbytes);
		@(posedge sys_clk);
		code_format_select <= 1'($random(seed));
		master.xfer({slave_addr, 1'b0}, w, nbytes, {$random(seed)} % 2, ack);
		check(32'(ack), 32'h1);
		if (nbytes == 3) model_cmd(w);
		repeat (8) @(posedge sys_clk);
		check_all();
	endtask : send
	function automatic logic [23:0] rcmd();
		logic [23:0] w;
		w = 24'($random(seed));
		case ({$random(seed)} % 4)
			0: w[23:20] = 4'h8;
			1: w[23:20] = 4'h9;
			2: w[23:20] = 4'h3;
			default: w[23:20] = 4'h4;
		endcase
		if (w[23:20] == 4'h3 && w[19]) w[19:16] = 4'hF;
		return w;
	endfunction : rcmd
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// bound on the whole run; running out counts as a mismatch
	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		resetn = 1'b0;
		code_format_select = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		checked = 0;
		miscompares = 0;
		do_reset();
		check_all();
		reg_read(dac_ref_pkg::REG_CTRL, rd);
		check(rd, 32'h48);
		reg_read(4'h8, rd);
		check(rd, 32'h0);
		reg_write(dac_ref_pkg::REG_STATUS, 32'hFFFFFFFF);
		check_all();
		foreach (CORNER[i]) send(CORNER[i], 3);
		send(e_static ? 24'h800000 : 24'h800010, 2);
		send(24'h3F1230, 1);
		master.xfer({slave_addr ^ 7'h01, 1'b0}, 24'h800000, 3, 0, ack);
		check(32'(ack), 32'h0);
		master.xfer({slave_addr, 1'b1}, 24'h800000, 3, 1, ack);
		check(32'(ack), 32'h0);
		check_all();
		reg_write(dac_ref_pkg::REG_CTRL, 32'h2A);
		slave_addr = 7'h2A;
		repeat (40) send(rcmd(), 3);
		send(24'h401FE0, 3);
		send(24'h900000, 3);
		send(24'h800010, 3);
		do_reset();
		check_all();
		print_verdict();
	end
endmodule : dac_reference_control_tb
`default_nettype wire
